// >>> hpe_dev_model.sv
// hpe_dev_model: behavioural peripheral on the host ports, giving line states, pins and handshakes
`timescale 1ns/1ps
module hpe_dev_model (
  input wire logic clk_i,
  output logic [1:0] line0_o,
  output logic [1:0] line1_o,
  output logic oc0_o,
  output logic oc1_o,
  output logic pd_o,
  output hpe_pkg::hpe_setup_evt_t setup_evt_o
);
  // ****************************************************************
  // pin levels
  // ****************************************************************
  // a detached port rests in se0, all pins low
  initial
  begin
    line0_o = hpe_pkg::HPE_LS_SE0;
    line1_o = hpe_pkg::HPE_LS_SE0;
    {oc1_o, oc0_o, pd_o} = 3'h0;
    setup_evt_o = '0;
  end

  // ****************************************************************
  // tasks the bench calls
  // ****************************************************************
  // one handshake per finished setup; an idle cycle follows each pulse
  task automatic respond(input hpe_pkg::hpe_setup_resp_t r);
    @(posedge clk_i);
    setup_evt_o <= '{valid: 1'b1, resp: r};
    @(posedge clk_i);
    setup_evt_o <= '0;
  endtask : respond

  // pin changes land just after an edge, never mid-cycle
  task automatic set_pins(input logic [1:0] l0, input logic [1:0] l1, input logic [2:0] p);
    @(posedge clk_i);
    line0_o <= l0;
    line1_o <= l1;
    {oc1_o, oc0_o, pd_o} <= p;
  endtask : set_pins
endmodule : hpe_dev_model

// >>> hpe_pkg.sv
// hpe_pkg: constants, field layout and carrier types of the host port event status block
package hpe_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [31:0] HPE_IDX_ST0 = 32'h000F0442; // port0_event_status
  localparam logic [31:0] HPE_IDX_ST1 = 32'h000F0444; // port1_event_status
  localparam logic [31:0] HPE_IDX_EN0 = 32'h00000100; // port 0 interrupt enables
  localparam logic [31:0] HPE_IDX_EN1 = 32'h00000101; // port 1 interrupt enables
  localparam logic [31:0] HPE_IDX_CTRL = 32'h00000102; // mode, clock and port activity
  localparam logic [31:0] HPE_IDX_SYS = 32'h00000103; // port1_system_status, read only

  // ****************************************************************
  // status field positions and masks
  // ****************************************************************
  localparam int HPE_B_OVC = 15;
  localparam int HPE_B_BUS_CHANGE_FLAG = 14;
  localparam int HPE_B_DISCONNECT_FLAG = 12;
  localparam int HPE_B_ATTACH_FLAG = 11;
  localparam int HPE_B_EOF = 6;
  localparam int HPE_B_SIGN = 5;
  localparam int HPE_B_SETUP_ACK_FLAG = 4;
  localparam int HPE_B_PD = 0;
  localparam logic [15:0] HPE_MASK0 = 16'hD871;
  localparam logic [15:0] HPE_MASK1 = 16'hD841;
  localparam logic [15:0] HPE_HOSTONLY = 16'h7FFF; // everything but overcurrent
  localparam logic [15:0] HPE_ST_RESET = 16'h0000;
  localparam logic [15:0] HPE_EN_RESET = 16'h0000;

  // ****************************************************************
  // control and system status fields
  // ****************************************************************
  localparam int HPE_C_HOST = 0;
  localparam int HPE_C_CLKEN = 1;
  localparam int HPE_C_ACT0 = 2;
  localparam int HPE_S_PDLVL = 0;
  localparam int HPE_S_LS0 = 2;
  localparam int HPE_S_LS1 = 4;

  // ****************************************************************
  // line states and timing
  // ****************************************************************
  localparam logic [1:0] HPE_LS_SE0 = 2'h0;
  localparam logic [1:0] HPE_LS_J = 2'h1;
  localparam logic [1:0] HPE_LS_K = 2'h2;
  localparam logic [1:0] HPE_LS_SE1 = 2'h3;
  localparam real HPE_CLK_MHZ = 200.0;
  localparam real HPE_ATTACH_TIME_US = 2.5;
  localparam real HPE_DISC_TIME_US = 2.0;
  localparam int HPE_ATTACH_CYC = int'($ceil(HPE_ATTACH_TIME_US * HPE_CLK_MHZ));
  localparam int HPE_DISC_CYC = int'($ceil(HPE_DISC_TIME_US * HPE_CLK_MHZ));
  localparam int HPE_CNT_W = 10;
  localparam logic [1:0] HPE_SETUP_LAST = 2'h2; // third failure in a row

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef enum logic [2:0] {
    HPE_RESP_ACK = 3'h0,
    HPE_RESP_NONE = 3'h1,
    HPE_RESP_BADACK = 3'h2,
    HPE_RESP_NAK = 3'h3,
    HPE_RESP_NYET = 3'h4,
    HPE_RESP_STALL = 3'h5
  } hpe_setup_resp_t;

  typedef struct packed {
    logic valid;
    hpe_setup_resp_t resp;
  } hpe_setup_evt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } hpe_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hpe_apb_rsp_t;

  function automatic logic hpe_hit(input logic [31:0] paddr, input logic [31:0] idx);
    hpe_hit = (paddr == {idx[29:0], 2'b00});
  endfunction : hpe_hit

endpackage : hpe_pkg

// >>> hpe_top.sv
// hpe_top: event detection and status latching for both host ports, APB register slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module hpe_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire hpe_pkg::hpe_apb_req_t apb_req_i,
  output hpe_pkg::hpe_apb_rsp_t apb_rsp_o,
  input wire hpe_pkg::hpe_setup_evt_t setup_evt_i,
  input wire logic [1:0] eof2_point_i,
  input wire logic [1:0] trans_busy_i,
  input wire logic [1:0] port0_line_state_i,
  input wire logic [1:0] port1_line_state_i,
  input wire logic port0_overcurrent_in_i,
  input wire logic port1_overcurrent_in_i,
  input wire logic portable_detect_in_i,
  output logic [1:0] irq_o,
  output logic [1:0] port_active_o,
  output logic [1:0] port_idle_o
);

  // counter width from the package, named locally so casts stay short
  localparam int HPE_CNT_W = hpe_pkg::HPE_CNT_W;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [15:0] st_q [2];
  logic [15:0] st_d [2];
  logic [15:0] en_q [2];
  logic [15:0] en_d [2];
  logic [1:0] ls_q [2];
  logic [1:0] ls_d [2];
  logic [HPE_CNT_W-1:0] att_cnt_q [2];
  logic [HPE_CNT_W-1:0] att_cnt_d [2];
  logic [HPE_CNT_W-1:0] disc_cnt_q [2];
  logic [HPE_CNT_W-1:0] disc_cnt_d [2];
  logic [1:0] att_arm_q;
  logic [1:0] att_arm_d;
  logic [1:0] oc_q;
  logic [1:0] oc_d;
  logic [1:0] act_q;
  logic [1:0] act_d;
  logic [1:0] irq_q;
  logic [1:0] irq_d;
  logic [1:0] idle_q;
  logic [1:0] idle_d;
  logic [1:0] setup_cnt_q;
  logic [1:0] setup_cnt_d;
  logic pd_q;
  logic pd_d;
  logic host_q;
  logic host_d;
  logic clken_q;
  logic clken_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // per-port views and event vectors
  logic [1:0] ls_cur [2];
  logic [1:0] oc_cur;
  logic [15:0] ev [2];
  logic [15:0] mask [2];
  logic setup_fail;
  logic wr_fire;
  logic [1:0] clr_sel;

  assign ls_cur[0] = port0_line_state_i;
  assign ls_cur[1] = port1_line_state_i;
  assign oc_cur = {port1_overcurrent_in_i, port0_overcurrent_in_i};
  assign mask[0] = hpe_pkg::HPE_MASK0;
  assign mask[1] = hpe_pkg::HPE_MASK1;
  // write is taken only at the edge where the master sees pready high
  assign wr_fire = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & pready_q;
  assign clr_sel[0] = wr_fire & hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_ST0);
  assign clr_sel[1] = wr_fire & hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_ST1);
  assign setup_fail = setup_evt_i.valid & (setup_evt_i.resp != hpe_pkg::HPE_RESP_ACK);

  // ****************************************************************
  // event detection, both ports
  // ****************************************************************
  // attach, disconnect, eof, setup and pd need host mode and the clock; overcurrent and bus change run free
  always_comb
  begin
    ls_d = ls_cur;
    oc_d = oc_cur;
    pd_d = portable_detect_in_i;
    att_cnt_d = att_cnt_q;
    att_arm_d = att_arm_q;
    disc_cnt_d = disc_cnt_q;
    setup_cnt_d = setup_cnt_q;
    for (int p = 0; p < 2; p++)
    begin
      ev[p] = 16'h0000;
      // overcurrent and bus change survive a stopped clock
      ev[p][hpe_pkg::HPE_B_OVC] = oc_cur[p] ^ oc_q[p];
      ev[p][hpe_pkg::HPE_B_BUS_CHANGE_FLAG] = (ls_cur[p] != ls_q[p]) &&
        (ls_cur[p] != hpe_pkg::HPE_LS_SE1) && (ls_q[p] != hpe_pkg::HPE_LS_SE1);
      if (host_q && clken_q)
      begin
        // attach: entry into j or k, then held for the full time
        if (ls_cur[p] != ls_q[p])
        begin
          att_arm_d[p] = (ls_cur[p] == hpe_pkg::HPE_LS_J) || (ls_cur[p] == hpe_pkg::HPE_LS_K);
          att_cnt_d[p] = '0;
        end
        else if (att_arm_q[p])
        begin
          if (att_cnt_q[p] == HPE_CNT_W'(hpe_pkg::HPE_ATTACH_CYC - 1))
          begin
            ev[p][hpe_pkg::HPE_B_ATTACH_FLAG] = 1'b1;
            att_arm_d[p] = 1'b0;
          end
          else
          begin
            att_cnt_d[p] = att_cnt_q[p] + HPE_CNT_W'(1);
          end
        end
        // disconnect: se0 held on an active port
        if (act_q[p] && (ls_cur[p] == hpe_pkg::HPE_LS_SE0))
        begin
          if (disc_cnt_q[p] == HPE_CNT_W'(hpe_pkg::HPE_DISC_CYC - 1))
          begin
            ev[p][hpe_pkg::HPE_B_DISCONNECT_FLAG] = 1'b1;
            disc_cnt_d[p] = '0;
          end
          else
          begin
            disc_cnt_d[p] = disc_cnt_q[p] + HPE_CNT_W'(1);
          end
        end
        else
        begin
          disc_cnt_d[p] = '0;
        end
        ev[p][hpe_pkg::HPE_B_EOF] = eof2_point_i[p] & trans_busy_i[p] & act_q[p];
      end
    end
    // setup transactions and portable detect belong to port 0 only
    if (host_q && clken_q)
    begin
      ev[0][hpe_pkg::HPE_B_PD] = portable_detect_in_i ^ pd_q;
      if (setup_evt_i.valid && !setup_fail)
      begin
        ev[0][hpe_pkg::HPE_B_SETUP_ACK_FLAG] = 1'b1;
        setup_cnt_d = 2'h0;
      end
      else if (setup_fail)
      begin
        if (setup_cnt_q == hpe_pkg::HPE_SETUP_LAST)
        begin
          ev[0][hpe_pkg::HPE_B_SIGN] = 1'b1;
          setup_cnt_d = 2'h0;
        end
        else
        begin
          setup_cnt_d = setup_cnt_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      ls_q <= '{default: hpe_pkg::HPE_LS_SE0};
      oc_q <= 2'h0;
      pd_q <= 1'b0;
      att_cnt_q <= '{default: '0};
      att_arm_q <= 2'h0;
      disc_cnt_q <= '{default: '0};
      setup_cnt_q <= 2'h0;
    end
    else
    begin
      ls_q <= ls_d;
      oc_q <= oc_d;
      pd_q <= pd_d;
      att_cnt_q <= att_cnt_d;
      att_arm_q <= att_arm_d;
      disc_cnt_q <= disc_cnt_d;
      setup_cnt_q <= setup_cnt_d;
    end
  end

  // ****************************************************************
  // status flags, enables, control, interrupts
  // ****************************************************************
  // write-zero-to-clear; a new event in the same cycle keeps the flag
  always_comb
  begin
    host_d = host_q;
    clken_d = clken_q;
    act_d = act_q;
    en_d = en_q;
    if (wr_fire && hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_CTRL))
    begin
      host_d = apb_req_i.pwdata[hpe_pkg::HPE_C_HOST];
      clken_d = apb_req_i.pwdata[hpe_pkg::HPE_C_CLKEN];
      act_d = apb_req_i.pwdata[hpe_pkg::HPE_C_ACT0 +: 2];
    end
    if (wr_fire && hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_EN0))
    begin
      en_d[0] = apb_req_i.pwdata[15:0] & hpe_pkg::HPE_MASK0;
    end
    if (wr_fire && hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_EN1))
    begin
      en_d[1] = apb_req_i.pwdata[15:0] & hpe_pkg::HPE_MASK1;
    end
    for (int p = 0; p < 2; p++)
    begin
      st_d[p] = st_q[p];
      if (clr_sel[p])
      begin
        st_d[p] = st_q[p] & apb_req_i.pwdata[15:0];
      end
      st_d[p] = (st_d[p] | ev[p]) & mask[p];
      // hardware idles the port whatever the enable says
      idle_d[p] = ev[p][hpe_pkg::HPE_B_EOF] | ev[p][hpe_pkg::HPE_B_DISCONNECT_FLAG];
      if (idle_d[p])
      begin
        act_d[p] = 1'b0;
      end
      irq_d[p] = |(st_q[p] & en_q[p]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= '{default: hpe_pkg::HPE_ST_RESET};
      en_q <= '{default: hpe_pkg::HPE_EN_RESET};
      host_q <= 1'b0;
      clken_q <= 1'b0;
      act_q <= 2'h0;
      idle_q <= 2'h0;
      irq_q <= 2'h0;
    end
    else
    begin
      st_q <= st_d;
      en_q <= en_d;
      host_q <= host_d;
      clken_q <= clken_d;
      act_q <= act_d;
      idle_q <= idle_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************************************
  // apb slave: one wait state, registered answer
  // ****************************************************************
  // function mode hides the host-only flags rather than showing stale ones
  always_comb
  begin
    pready_d = apb_req_i.psel & apb_req_i.penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = 32'h00000000;
    if (pready_d && !apb_req_i.pwrite)
    begin
      if (hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_ST0))
      begin
        prdata_d[15:0] = st_q[0] & (host_q ? 16'hFFFF : ~hpe_pkg::HPE_HOSTONLY);
      end
      else if (hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_ST1))
      begin
        prdata_d[15:0] = st_q[1] & (host_q ? 16'hFFFF : ~hpe_pkg::HPE_HOSTONLY);
      end
      else if (hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_EN0))
      begin
        prdata_d[15:0] = en_q[0];
      end
      else if (hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_EN1))
      begin
        prdata_d[15:0] = en_q[1];
      end
      else if (hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_CTRL))
      begin
        prdata_d[hpe_pkg::HPE_C_HOST] = host_q;
        prdata_d[hpe_pkg::HPE_C_CLKEN] = clken_q;
        prdata_d[hpe_pkg::HPE_C_ACT0 +: 2] = act_q;
      end
      else if (hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_SYS))
      begin
        prdata_d[hpe_pkg::HPE_S_PDLVL] = pd_q;
        prdata_d[hpe_pkg::HPE_S_LS0 +: 2] = ls_q[0];
        prdata_d[hpe_pkg::HPE_S_LS1 +: 2] = ls_q[1];
      end
      else
      begin
        pslverr_d = 1'b1;
      end
    end
    else if (pready_d)
    begin
      // writes are checked against the same map
      pslverr_d = !(hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_ST0) ||
        hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_ST1) ||
        hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_EN0) ||
        hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_EN1) ||
        hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_CTRL) ||
        hpe_pkg::hpe_hit(apb_req_i.paddr, hpe_pkg::HPE_IDX_SYS));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // outputs straight from flops
  assign apb_rsp_o.pready = pready_q;
  assign apb_rsp_o.pslverr = pslverr_q;
  assign apb_rsp_o.prdata = prdata_q;
  assign irq_o = irq_q;
  assign port_active_o = act_q;
  assign port_idle_o = idle_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_irq_needs_enable: assert property (
    ##1 (irq_o[1] == $past(|(st_q[1] & en_q[1]))))
    else $error("port 1 interrupt does not follow flag and enable");
  a_eof_flag_set: assert property (
    host_q && clken_q && eof2_point_i[1] && trans_busy_i[1] && act_q[1]
    |=> st_q[1][hpe_pkg::HPE_B_EOF] ##1 (port_idle_o[1] == 1'b0 || !act_q[1]))
    else $error("eof error flag not set");
  a_eof_drops_active: assert property (
    ev[1][hpe_pkg::HPE_B_EOF] |=> !port_active_o[1] && port_idle_o[1])
    else $error("eof error left port active");
  a_setup_third_fail: assert property (
    setup_fail && host_q && clken_q && setup_cnt_q == 2'h2 |=> st_q[0][hpe_pkg::HPE_B_SIGN])
    else $error("third setup failure did not set error");
  a_setup_fail_counts: assert property (
    setup_evt_i.valid && host_q && clken_q && setup_cnt_q == 2'h0 &&
    setup_evt_i.resp inside {hpe_pkg::HPE_RESP_NONE, hpe_pkg::HPE_RESP_BADACK,
    hpe_pkg::HPE_RESP_NAK, hpe_pkg::HPE_RESP_NYET, hpe_pkg::HPE_RESP_STALL}
    |=> setup_cnt_q == 2'h1)
    else $error("failed setup response not counted");
  a_setup_ack_flag: assert property (
    setup_evt_i.valid && !setup_fail && host_q && clken_q
    |=> st_q[0][hpe_pkg::HPE_B_SETUP_ACK_FLAG] && setup_cnt_q == 2'h0)
    else $error("setup ack not flagged");
  a_pd_edge_flag: assert property (
    host_q && clken_q && $changed(portable_detect_in_i) |=> st_q[0][hpe_pkg::HPE_B_PD])
    else $error("portable detect edge missed");
  a_pd_level_bit: assert property (
    ##1 (pd_q == $past(portable_detect_in_i)))
    else $error("portable detect level stale");
  a_clock_stop_quiet: assert property (
    !clken_q && !st_q[1][hpe_pkg::HPE_B_ATTACH_FLAG] |=> !st_q[1][hpe_pkg::HPE_B_ATTACH_FLAG])
    else $error("attach detected while clock stopped");
  a_ovc_edge_flag: assert property (
    $changed(port1_overcurrent_in_i) |=> st_q[1][hpe_pkg::HPE_B_OVC])
    else $error("overcurrent edge missed");
  a_bus_change_flag: assert property (
    $changed(port1_line_state_i) && port1_line_state_i != hpe_pkg::HPE_LS_SE1 &&
    $past(port1_line_state_i) != hpe_pkg::HPE_LS_SE1 |=> st_q[1][hpe_pkg::HPE_B_BUS_CHANGE_FLAG])
    else $error("bus change missed");
  a_disc_drops_active: assert property (
    ev[0][hpe_pkg::HPE_B_DISCONNECT_FLAG] |=> st_q[0][hpe_pkg::HPE_B_DISCONNECT_FLAG] && !port_active_o[0])
    else $error("disconnect did not flag and idle");
  a_attach_after_count: assert property (
    $rose(st_q[0][hpe_pkg::HPE_B_ATTACH_FLAG]) && !$past(clr_sel[0])
    |-> $past(att_cnt_q[0]) == HPE_CNT_W'(hpe_pkg::HPE_ATTACH_CYC - 1))
    else $error("attach flagged before full hold time");
  a_reserved_zero: assert property (
    (st_q[1] & ~hpe_pkg::HPE_MASK1) == 16'h0000 && (st_q[0] & ~hpe_pkg::HPE_MASK0) == 16'h0000)
    else $error("unassigned status bit set");
  a_set_beats_clear: assert property (
    clr_sel[1] && ev[1][hpe_pkg::HPE_B_OVC] |=> st_q[1][hpe_pkg::HPE_B_OVC])
    else $error("event lost under clear");

  c_attach_seen: cover property ($rose(st_q[1][hpe_pkg::HPE_B_ATTACH_FLAG]));
  c_disconnect_seen: cover property ($rose(st_q[1][hpe_pkg::HPE_B_DISCONNECT_FLAG]));
  c_setup_error_seen: cover property ($rose(st_q[0][hpe_pkg::HPE_B_SIGN]));
  c_irq_raised: cover property ($rose(irq_o[0]));

endmodule : hpe_top

// >>> hpe_top_tb_top.sv
// hpe_top_tb_top: self-checking bench for the host port event status block
`timescale 1ns/1ps
module hpe_top_tb_top;
  logic clk;
  logic rst;
  hpe_pkg::hpe_apb_req_t req;
  hpe_pkg::hpe_apb_rsp_t rsp;
  hpe_pkg::hpe_setup_evt_t evt;
  logic [1:0] eof2;
  logic [1:0] busy;
  logic [1:0] l0;
  logic [1:0] l1;
  logic oc0;
  logic oc1;
  logic pd;
  logic [1:0] irq;
  logic [1:0] act;
  logic [1:0] idle;
  logic [15:0] lfsr_q;
  logic [31:0] rd;
  logic e;
  int err_total;
  int n_compared;

  hpe_top i_hpe_top (.clk_i(clk), .sys_rst_i(rst), .apb_req_i(req), .apb_rsp_o(rsp),
    .setup_evt_i(evt), .eof2_point_i(eof2), .trans_busy_i(busy), .port0_line_state_i(l0),
    .port1_line_state_i(l1), .port0_overcurrent_in_i(oc0), .port1_overcurrent_in_i(oc1),
    .portable_detect_in_i(pd), .irq_o(irq), .port_active_o(act), .port_idle_o(idle));

  hpe_dev_model i_hpe_dev_model (.clk_i(clk), .line0_o(l0), .line1_o(l1), .oc0_o(oc0),
    .oc1_o(oc1), .pd_o(pd), .setup_evt_o(evt));

  // ****************************************************************
  // clock, checking and bus tasks
  // ****************************************************************
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // request held until pready is sampled high; the bound cuts a hang short
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx[29:0], 2'b00}, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1)
    begin
      err_total++;
      finish_test();
    end
    rd = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic rdchk(input string what, input logic [31:0] idx, input logic [15:0] m,
    input logic [15:0] exp);
    apb(1'b0, idx, 32'h0);
    // upper half must read zero; only the masked bits of the low half are judged
    chk(what, rd, {16'h0000, (exp & m) | (rd[15:0] & ~m)});
  endtask : rdchk

  function automatic hpe_pkg::hpe_setup_resp_t rnd_fail();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return hpe_pkg::hpe_setup_resp_t'(3'(lfsr_q % 16'h5) + 3'h1);
  endfunction : rnd_fail

  // three handshakes, then flags and irq against the expected pair, then a clear
  task automatic setup3(input hpe_pkg::hpe_setup_resp_t a, input hpe_pkg::hpe_setup_resp_t b,
    input hpe_pkg::hpe_setup_resp_t c, input logic [15:0] exp);
    i_hpe_dev_model.respond(a);
    i_hpe_dev_model.respond(b);
    i_hpe_dev_model.respond(c);
    repeat (3) @(posedge clk);
    rdchk("setup flags", hpe_pkg::HPE_IDX_ST0, 16'h0030, exp);
    chk("port0 irq", {31'h0, irq[0]}, {31'h0, |exp});
    apb(1'b1, hpe_pkg::HPE_IDX_ST0, {16'h0000, hpe_pkg::HPE_MASK0 & ~exp});
  endtask : setup3

  // ****************************************************************
  // main sequence
  // ****************************************************************
  // reset for 8 cycles, then one scenario after another
  initial
  begin
    {rst, req, eof2, busy, err_total, n_compared} = '1;
    {req, eof2, busy, err_total, n_compared} = '0;
    lfsr_q = 16'h000A;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdchk("status0 reset", hpe_pkg::HPE_IDX_ST0, 16'hFFFF, 16'h0);
    rdchk("status1 reset", hpe_pkg::HPE_IDX_ST1, 16'hFFFF, 16'h0);
    apb(1'b1, hpe_pkg::HPE_IDX_CTRL, 32'h3);
    apb(1'b1, hpe_pkg::HPE_IDX_EN0, 32'hFFFF);
    apb(1'b1, hpe_pkg::HPE_IDX_EN1, 32'hFFFF);
    setup3(rnd_fail(), rnd_fail(), hpe_pkg::HPE_RESP_ACK, 16'h0010);
    setup3(hpe_pkg::HPE_RESP_NONE, hpe_pkg::HPE_RESP_BADACK, hpe_pkg::HPE_RESP_ACK, 16'h0010);
    setup3(hpe_pkg::HPE_RESP_NAK, hpe_pkg::HPE_RESP_NYET, hpe_pkg::HPE_RESP_STALL, 16'h0020);
    // attach needs j held 501 cycles: look just before and after
    i_hpe_dev_model.set_pins(hpe_pkg::HPE_LS_J, hpe_pkg::HPE_LS_SE0, 3'h0);
    repeat (480) @(posedge clk);
    rdchk("attach early", hpe_pkg::HPE_IDX_ST0, 16'h0800, 16'h0);
    repeat (30) @(posedge clk);
    rdchk("attach", hpe_pkg::HPE_IDX_ST0, 16'h4800, 16'h4800);
    apb(1'b1, hpe_pkg::HPE_IDX_ST0, 32'h9071);
    // end of frame on both ports, only port 1 busy
    apb(1'b1, hpe_pkg::HPE_IDX_CTRL, 32'hF);
    @(posedge clk);
    eof2 <= 2'h3;
    busy <= 2'h2;
    @(posedge clk);
    {eof2, busy} <= 4'h0;
    @(posedge clk);
    chk("idle pulse", {30'h0, idle}, 32'h2);
    chk("active", {30'h0, act}, 32'h1);
    rdchk("eof port1", hpe_pkg::HPE_IDX_ST1, 16'h0040, 16'h0040);
    rdchk("eof port0", hpe_pkg::HPE_IDX_ST0, 16'h0040, 16'h0);
    apb(1'b1, hpe_pkg::HPE_IDX_ST1, 32'hD801);
    // se0 on the active port for 400 cycles means disconnect
    i_hpe_dev_model.set_pins(hpe_pkg::HPE_LS_SE0, hpe_pkg::HPE_LS_SE0, 3'h0);
    repeat (390) @(posedge clk);
    chk("active kept", {31'h0, act[0]}, 32'h1);
    repeat (20) @(posedge clk);
    chk("active dropped", {30'h0, act}, 32'h0);
    rdchk("disconnect", hpe_pkg::HPE_IDX_ST0, 16'h1000, 16'h1000);
    apb(1'b1, hpe_pkg::HPE_IDX_ST0, 32'h8871);
    // clock stopped: only overcurrent and bus change may latch
    apb(1'b1, hpe_pkg::HPE_IDX_CTRL, 32'h1);
    i_hpe_dev_model.set_pins(hpe_pkg::HPE_LS_SE0, hpe_pkg::HPE_LS_J, 3'h5);
    repeat (5) @(posedge clk);
    rdchk("clock off port1", hpe_pkg::HPE_IDX_ST1, 16'hC000, 16'hC000);
    rdchk("clock off pd", hpe_pkg::HPE_IDX_ST0, 16'h0001, 16'h0);
    chk("port1 irq", {31'h0, irq[1]}, 32'h1);
    repeat (3) rdchk("line state", hpe_pkg::HPE_IDX_SYS, 16'h0030, 16'h0010);
    apb(1'b1, hpe_pkg::HPE_IDX_CTRL, 32'h3);
    // overcurrent pin falls so that its event lands on the edge of the clear
    fork
      apb(1'b1, hpe_pkg::HPE_IDX_ST1, 32'h1841);
      begin
        repeat (2) @(posedge clk);
        i_hpe_dev_model.set_pins(hpe_pkg::HPE_LS_SE0, hpe_pkg::HPE_LS_J, 3'h1);
      end
    join
    rdchk("set beats clear", hpe_pkg::HPE_IDX_ST1, 16'hC000, 16'h8000);
    apb(1'b1, hpe_pkg::HPE_IDX_ST1, 32'h5841);
    rdchk("port1 cleared", hpe_pkg::HPE_IDX_ST1, 16'hC000, 16'h0);
    // portable detect falls: flag set, level read three times
    i_hpe_dev_model.set_pins(hpe_pkg::HPE_LS_SE0, hpe_pkg::HPE_LS_J, 3'h4);
    repeat (3) @(posedge clk);
    rdchk("pd flag", hpe_pkg::HPE_IDX_ST0, 16'h0001, 16'h0001);
    repeat (3) rdchk("pd level", hpe_pkg::HPE_IDX_SYS, 16'h0001, 16'h0);
    // irq follows the enable while the flag stays
    apb(1'b1, hpe_pkg::HPE_IDX_EN0, 32'h0);
    repeat (3) @(posedge clk);
    chk("masked irq", {31'h0, irq[0]}, 32'h0);
    apb(1'b1, hpe_pkg::HPE_IDX_EN0, 32'h1);
    repeat (3) @(posedge clk);
    chk("unmasked irq", {31'h0, irq[0]}, 32'h1);
    rdchk("unassigned", hpe_pkg::HPE_IDX_ST1, 16'h27BE, 16'h0);
    apb(1'b1, hpe_pkg::HPE_IDX_CTRL, 32'h0);
    rdchk("function mode", hpe_pkg::HPE_IDX_ST0, 16'h7FFF, 16'h0);
    // unmapped place is refused
    apb(1'b0, 32'h00000200, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    finish_test();
  end
endmodule : hpe_top_tb_top
